// ---- src/tps_consts.svh ----
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

// Master clock rate and the documented times in their own units.
`define TPS_CLK_KHZ 40000
`define TPS_STEP_BASE_US 2000
`define TPS_REFRESH_US 400
`define TPS_SETTLE_MS 120

// Cycle counts derived from the times above.
`define TPS_STEP_CYCLES ((`TPS_STEP_BASE_US * `TPS_CLK_KHZ) / 1000)
`define TPS_REFRESH_CYCLES ((`TPS_REFRESH_US * `TPS_CLK_KHZ) / 1000)
`define TPS_SETTLE_CYCLES (`TPS_SETTLE_MS * `TPS_CLK_KHZ)

// Register byte offsets.
`define TPS_OFS_CFG 8'h00
`define TPS_OFS_DELAY 8'h04
`define TPS_OFS_STATUS 8'h08

// Configuration register fields.
`define TPS_CFG_COL_LSB 0
`define TPS_CFG_ORDER_LSB 4
`define TPS_CFG_COL_RESET 2'h0
`define TPS_CFG_ORDER_RESET 3'h1

// Delay register: six 4-bit fields, delay 1 in the low nibble.
`define TPS_DELAY_RESET 24'h00_0000

// Status register fields.
`define TPS_ST_STATE_LSB 0
`define TPS_ST_REL_LSB 4
`define TPS_ST_EN_BIT 7
`define TPS_ST_ABORT_BIT 8
`define TPS_ST_PIN_LSB 9

// Down-order permutations as {first, second, third} gate indices.
`define TPS_ORD_1 6'b10_01_00
`define TPS_ORD_2 6'b10_00_01
`define TPS_ORD_3 6'b01_10_00
`define TPS_ORD_4 6'b01_00_10
`define TPS_ORD_5 6'b00_10_01
`define TPS_ORD_6 6'b00_01_10

`endif

// ---- src/tps_pkg.sv ----
`default_nettype none

package tps_pkg;

    // Sequencer states, Gray coded along the usual up-then-down path.
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_UP1    = 4'b0001,
        ST_UP2    = 4'b0011,
        ST_UP3    = 4'b0010,
        ST_ON     = 4'b0110,
        ST_DN1    = 4'b0111,
        ST_DN2    = 4'b0101,
        ST_DN3    = 4'b0100,
        ST_SETTLE = 4'b1100
    } tps_state_t;

    // Software configuration that shapes one whole sequence.
    typedef struct packed {
        logic [2:0] order;
        logic [1:0] column;
        logic [23:0] delays;
    } tps_cfg_t;

endpackage

`default_nettype wire

// ---- src/tps_sequencer.sv ----
// Functional notes
// - All three gates stay held low after reset until enable is seen high.
// - Enable rising starts the first delay; gate 1 releases when it expires.
// - Each release starts the next delay; gates 2 then 3 release on expiry.
// - Power-up order is fixed: gate 1, then gate 2, then gate 3.
// - Enable falling after full power-up times, then pulls gates low in order.
// - Three power-down delays are set apart from the three power-up delays.
// - Enable falling before gate 1 releases resets the timer, releases nothing.
// - Enable falling mid power-up restarts the timer and finishes releasing.
// - After such an interrupted power-up, wait 120 ms before power-down.
// - All six delays count from the one master clock.
// - Delays 1 and 4 get an extra 400 us refresh time added.
// - Each delay is 0 to 15 times a step of 2, 4, 6 or 8 ms.
// - One step column is shared by all six delays.
// - Power-down order is chosen from six permutations, apart from delays.
// - Reset configuration is order 1: up 1-2-3, down 3-2-1.
// - Order codes 1 to 6 give 321, 312, 231, 213, 132, 123.
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "tps_consts.svh"
`default_nettype none

module tps_sequencer
    import tps_pkg::*;
#(
    parameter int STEP_CYCLES = `TPS_STEP_CYCLES,
    parameter int REFRESH_CYCLES = `TPS_REFRESH_CYCLES,
    parameter int SETTLE_CYCLES = `TPS_SETTLE_CYCLES,
    parameter int CNT_W = 24
) (
    input wire logic mclk, // Master clock, 40 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic enIn, // Enable comparator output, asynchronous.
    input wire logic [2:0] railGateIn, // Sensed level of each gate pin.
    output logic [2:0] railGateOut, // Gate pin drive value, always low.
    output logic [2:0] railGateOe, // High while a gate pin is pulled low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr // APB error for an unmapped address.
);

    // Ordered gate indices for a down-order code; bad codes fall back to order 1.
    function automatic logic [5:0] downOrder(input logic [2:0] code);
        case (code)
            3'd2: downOrder = `TPS_ORD_2;
            3'd3: downOrder = `TPS_ORD_3;
            3'd4: downOrder = `TPS_ORD_4;
            3'd5: downOrder = `TPS_ORD_5;
            3'd6: downOrder = `TPS_ORD_6;
            default: downOrder = `TPS_ORD_1;
        endcase
    endfunction

    // Cycles for a delay field: index times the column step plus optional refresh.
    function automatic logic [CNT_W-1:0] delayCycles(input logic [3:0] idx,
                                                     input logic [1:0] col,
                                                     input logic refresh);
        int ticks;
        int cyc;
        ticks = int'(idx) * (int'(col) + 1);
        cyc = ticks * STEP_CYCLES + (refresh ? REFRESH_CYCLES : 0);
        delayCycles = CNT_W'(cyc);
    endfunction

    // Gate index of power-down step n under the running order.
    function automatic logic [1:0] downGate(input logic [5:0] ord, input int n);
        case (n)
            0: downGate = ord[5:4];
            1: downGate = ord[3:2];
            default: downGate = ord[1:0];
        endcase
    endfunction

    tps_state_t state_q, state_d;
    tps_cfg_t cfg_q, run_q;
    logic [1:0] enSync_q;
    logic enPrev_q;
    logic [2:0] pinSync0_q, pinSync1_q;
    logic [2:0] held_q, held_d;
    logic abort_q, abort_d;
    logic [2:0] zeroOut_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // Enable and pin levels come from outside the clock domain.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enSync_q <= 2'b00;
            enPrev_q <= 1'b0;
            pinSync0_q <= 3'b000;
            pinSync1_q <= 3'b000;
        end else begin
            enSync_q <= {enSync_q[0], enIn};
            enPrev_q <= enSync_q[1];
            pinSync0_q <= railGateIn;
            pinSync1_q <= pinSync0_q;
        end
    end

    wire enOn = enSync_q[1];
    wire enFall = enPrev_q && !enOn;

    // APB decode; one wait state so read data is always registered.
    wire setupPh = psel && !penable;
    wire accessPh = psel && penable && !pready_q;
    wire doneAcc = psel && penable && pready_q;
    wire hitCfg = (paddr == `TPS_OFS_CFG);
    wire hitDelay = (paddr == `TPS_OFS_DELAY);
    wire hitStatus = (paddr == `TPS_OFS_STATUS);
    wire hitAny = hitCfg || hitDelay || hitStatus;
    wire wrCfg = doneAcc && pwrite && hitCfg;
    wire wrDelay = doneAcc && pwrite && hitDelay;

    // Read multiplexer; unused bits read as zero.
    wire [31:0] rdCfg = {25'h0, cfg_q.order, 2'b00, cfg_q.column};
    wire [31:0] rdDelay = {8'h00, cfg_q.delays};
    wire [31:0] rdStatus = {20'h0, pinSync1_q, abort_q, enOn, ~held_q, state_q};
    wire [31:0] rdData = hitCfg ? rdCfg : (hitDelay ? rdDelay : (hitStatus ? rdStatus : '0));

    // Bus answer registers, loaded in the access phase and dropped after it.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= accessPh;
            pslverr_q <= accessPh && !hitAny;
            prdata_q <= (accessPh && !pwrite) ? rdData : 32'h0000_0000;
        end
    end

    // Software configuration. Writes to status are ignored.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_q.order <= `TPS_CFG_ORDER_RESET;
            cfg_q.column <= `TPS_CFG_COL_RESET;
            cfg_q.delays <= `TPS_DELAY_RESET;
        end else begin
            if (wrCfg) begin
                cfg_q.order <= pwdata[`TPS_CFG_ORDER_LSB +: 3];
                cfg_q.column <= pwdata[`TPS_CFG_COL_LSB +: 2];
            end
            if (wrDelay) begin
                cfg_q.delays <= pwdata[23:0];
            end
        end
    end

    // The running copy is frozen at the start of a sequence so that a mid-sequence
    // write cannot mix columns or change order halfway through.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_q.order <= `TPS_CFG_ORDER_RESET;
            run_q.column <= `TPS_CFG_COL_RESET;
            run_q.delays <= `TPS_DELAY_RESET;
        end else if (state_q == ST_IDLE) begin
            run_q <= cfg_q;
        end
    end

    wire [5:0] runOrd = downOrder(run_q.order);
    wire timerDone;

    // Sequencing decisions.
    always_comb begin
        state_d = state_q;
        held_d = held_q;
        abort_d = abort_q;
        case (state_q)
            ST_IDLE: begin
                held_d = 3'b111;
                abort_d = 1'b0;
                if (enOn) begin
                    state_d = ST_UP1;
                end
            end
            ST_UP1: begin
                if (!enOn) begin
                    state_d = ST_IDLE;
                end else if (timerDone) begin
                    held_d[0] = 1'b0;
                    state_d = ST_UP2;
                end
            end
            // A fall that meets expiry must not stall the walk, since no reload follows it.
            ST_UP2: begin
                if (enFall) begin
                    abort_d = 1'b1;
                end
                if (timerDone) begin
                    held_d[1] = 1'b0;
                    state_d = ST_UP3;
                end
            end
            ST_UP3: begin
                if (enFall) begin
                    abort_d = 1'b1;
                end
                if (timerDone) begin
                    held_d[2] = 1'b0;
                    state_d = (abort_q || enFall) ? ST_SETTLE : ST_ON;
                end
            end
            ST_ON: begin
                if (!enOn) begin
                    state_d = ST_DN1;
                end
            end
            ST_SETTLE: begin
                if (timerDone) begin
                    state_d = ST_DN1;
                end
            end
            ST_DN1: begin
                if (timerDone) begin
                    held_d[downGate(runOrd, 0)] = 1'b1;
                    state_d = ST_DN2;
                end
            end
            ST_DN2: begin
                if (timerDone) begin
                    held_d[downGate(runOrd, 1)] = 1'b1;
                    state_d = ST_DN3;
                end
            end
            ST_DN3: begin
                if (timerDone) begin
                    held_d[downGate(runOrd, 2)] = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                held_d = 3'b111;
                abort_d = 1'b0;
            end
        endcase
    end

    // Timer load: on each timed state entry, and again when an interrupt restarts it.
    wire restart = enFall && ((state_q == ST_UP2) || (state_q == ST_UP3)) && !timerDone;
    wire enterTimed = (state_d != state_q) && (state_d != ST_IDLE) && (state_d != ST_ON);
    wire loadT = enterTimed || restart;
    wire clearT = (state_d == ST_IDLE) || (state_d == ST_ON);
    tps_state_t loadSt;
    assign loadSt = restart ? state_q : state_d;
    logic [CNT_W-1:0] loadVal;

    // Delay selection per timed state; one field each except settle, delays 1 and 4 refreshed.
    always_comb begin
        case (loadSt)
            ST_UP1: loadVal = delayCycles(run_q.delays[3:0], run_q.column, 1'b1);
            ST_UP2: loadVal = delayCycles(run_q.delays[7:4], run_q.column, 1'b0);
            ST_UP3: loadVal = delayCycles(run_q.delays[11:8], run_q.column, 1'b0);
            ST_DN1: loadVal = delayCycles(run_q.delays[15:12], run_q.column, 1'b1);
            ST_DN2: loadVal = delayCycles(run_q.delays[19:16], run_q.column, 1'b0);
            ST_DN3: loadVal = delayCycles(run_q.delays[23:20], run_q.column, 1'b0);
            ST_SETTLE: loadVal = CNT_W'(SETTLE_CYCLES);
            default: loadVal = '0;
        endcase
    end

    // A single shared counter keeps the delay ratios exact.
    tps_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .load(loadT),
        .clear(clearT),
        .loadVal(loadVal),
        .expired(timerDone)
    );

    // State and output registers. A held gate drives its pin low.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            held_q <= 3'b111;
            abort_q <= 1'b0;
            zeroOut_q <= 3'b000;
        end else begin
            state_q <= state_d;
            held_q <= held_d;
            abort_q <= abort_d;
            zeroOut_q <= 3'b000;
        end
    end

    assign railGateOut = zeroOut_q;
    assign railGateOe = held_q;
    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // Checks on the sequencing.
    property p_idleHeld;
        @(posedge mclk) disable iff (rst) (state_q == ST_IDLE) |-> (held_q == 3'b111);
    endproperty
    a_idleHeld: assert property (p_idleHeld) else $error("gate released while idle");

    property p_gate1Cause;
        @(posedge mclk) disable iff (rst) $fell(held_q[0]) |-> $past(state_q == ST_UP1 && enOn);
    endproperty
    a_gate1Cause: assert property (p_gate1Cause) else $error("gate 1 released out of turn");

    property p_upOrder;
        @(posedge mclk) disable iff (rst)
            ($fell(held_q[1]) |-> !held_q[0]) and ($fell(held_q[2]) |-> !held_q[1]);
    endproperty
    a_upOrder: assert property (p_upOrder) else $error("power-up order broken");

    property p_glitch;
        @(posedge mclk) disable iff (rst) (state_q == ST_UP1 && !enOn) |=> (state_q == ST_IDLE);
    endproperty
    a_glitch: assert property (p_glitch) else $error("early enable drop not reset");

    property p_abortMark;
        @(posedge mclk) disable iff (rst)
            (enFall && (state_q == ST_UP2 || state_q == ST_UP3)) |=> abort_q || !held_q[2];
    endproperty
    a_abortMark: assert property (p_abortMark) else $error("interrupt not remembered");

    sequence s_settleIn;
        (state_q == ST_UP3) && timerDone && abort_q;
    endsequence
    property p_settle;
        @(posedge mclk) disable iff (rst) s_settleIn |=> (state_q == ST_SETTLE) && (held_q == 3'b000);
    endproperty
    a_settle: assert property (p_settle) else $error("no settle after interrupt");

    property p_sync;
        @(posedge mclk) disable iff (rst) ##2 (enOn == $past(enIn, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("enable sync depth wrong");

    property p_zeroDelay;
        @(posedge mclk) disable iff (rst) (loadT && loadVal == '0 && !clearT) |=> timerDone;
    endproperty
    a_zeroDelay: assert property (p_zeroDelay) else $error("zero delay not immediate");

    property p_upStart;
        @(posedge mclk) disable iff (rst) $rose(state_q == ST_UP1) |-> $past(state_q == ST_IDLE);
    endproperty
    a_upStart: assert property (p_upStart) else $error("power-up restarted mid power-down");

endmodule

`default_nettype wire

// ---- src/tps_timer.sv ----
`default_nettype none

module tps_timer #(
    parameter int CNT_W = 24
) (
    input wire logic mclk, // Master clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic load, // Start counting from loadVal.
    input wire logic clear, // Abandon the running count.
    input wire logic [CNT_W-1:0] loadVal, // Cycles to wait before expiry.
    output logic expired // High while a running count has reached zero.
);

    logic [CNT_W-1:0] cnt_q;
    logic run_q;

    // Expiry is combinational so a zero load ends one cycle after the load.
    assign expired = run_q && (cnt_q == '0);

    // One down counter serves every delay, so all share the master clock.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (load) begin
            cnt_q <= loadVal;
            run_q <= 1'b1;
        end else if (clear || expired) begin
            run_q <= 1'b0;
        end else if (run_q) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int STEP = 4;
    // Refresh wider than the window slack, so a lost or misplaced refresh shows.
    localparam int REFR = 7;
    localparam int SETTLE = 20;
    localparam int LIMIT = 40000;
    localparam int ORD [6][3] = '{'{2, 1, 0}, '{2, 0, 1}, '{1, 2, 0},
                                  '{1, 0, 2}, '{0, 2, 1}, '{0, 1, 2}};

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic enIn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] railGateOut;
    logic [2:0] railGateOe;
    logic [2:0] pinLevel;
    logic [31:0] cyc = 32'h0000_0000;
    logic [31:0] rd;
    logic er;
    int upAt [3];
    int dnAt [3];
    int nFail = 0;
    int nCompared = 0;

    tps_sequencer #(.STEP_CYCLES(STEP), .REFRESH_CYCLES(REFR), .SETTLE_CYCLES(SETTLE),
        .CNT_W(24)) dut (.mclk(mclk), .rst(rst), .enIn(enIn), .railGateIn(pinLevel),
        .railGateOut(railGateOut), .railGateOe(railGateOe), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    tps_reg_model regs (.mclk(mclk), .railGateOe(railGateOe), .railGateOut(railGateOut),
        .cyc(cyc), .pinLevel(pinLevel), .upAt(upAt), .dnAt(dnAt));

    // Clock at 40 MHz.
    always #12.5 mclk = ~mclk;

    task automatic endOfTest();
        $display("Compared %0d, failed %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Cycle count for stamps; a hang is cut short here.
    always @(posedge mclk) begin
        cyc <= cyc + 32'h0000_0001;
        if (cyc == 32'(LIMIT)) begin
            nFail++;
            endOfTest();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Interval check; the window absorbs sync and load latency.
    task automatic chkWin(input int got, input int n, input int lo);
        nCompared++;
        if (got < n + lo || got > n + lo + 5) begin
            nFail++;
            $display("MISMATCH %0t interval %0d expected %0d plus %0d", $time, got, n, lo);
        end
    endtask

    function automatic int dly(input int idx, input int col, input bit refresh);
        return idx * (col + 1) * STEP + (refresh ? REFR : 0);
    endfunction

    // One APB transfer; entered just after a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Extra edge lets the model stamp the change first.
    task automatic waitOe(input logic [2:0] v);
        while (railGateOe !== v) @(posedge mclk);
        @(posedge mclk);
    endtask

    task automatic cfg(input int code, input int col, input logic [23:0] dl);
        apb(1'b1, 8'h00, 32'((code << 4) | col));
        apb(1'b1, 8'h04, {8'h00, dl});
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'((code << 4) | col));
    endtask

    // Full power-up then power-down with timing and order checked.
    task automatic runSeq(input int code, input int col, input logic [23:0] dl);
        int t0;
        int g [3];
        g = ORD[(code >= 1 && code <= 6) ? code - 1 : 0];
        cfg(code, col, dl);
        t0 = int'(cyc);
        enIn <= 1'b1;
        waitOe(3'b000);
        chkWin(upAt[0] - t0, dly(dl[3:0], col, 1), 3);
        chkWin(upAt[1] - upAt[0], dly(dl[7:4], col, 0), 1);
        chkWin(upAt[2] - upAt[1], dly(dl[11:8], col, 0), 1);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk({25'h0, rd[11:9], rd[7:4]}, 32'h0000_007f);
        t0 = int'(cyc);
        enIn <= 1'b0;
        waitOe(3'b111);
        chkWin(dnAt[g[0]] - t0, dly(dl[15:12], col, 1), 3);
        chkWin(dnAt[g[1]] - dnAt[g[0]], dly(dl[19:16], col, 0), 1);
        chkWin(dnAt[g[2]] - dnAt[g[1]], dly(dl[23:20], col, 0), 1);
    endtask

    // Main sequence: defaults, bus errors, every order, then the corner cases.
    initial begin
        int t0;
        void'($urandom(2506));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (20) @(posedge mclk);
        chk({29'h0, railGateOe}, 32'h0000_0007);
        chk({29'h0, railGateOut}, 32'h0000_0000);
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_0010);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b1, 8'h08, 32'hffff_ffff);
        chk({31'h0, er}, 32'h0000_0000);
        runSeq(1, 0, 24'h00_0000);
        runSeq(1, 3, 24'hff_ffff);
        for (int c = 1; c <= 6; c++) runSeq(c, $urandom_range(3), 24'($urandom()));
        runSeq(0, 2, 24'h13_5724);
        runSeq(7, 1, 24'h65_4321);
        // Enable glitch shorter than the first delay.
        cfg(1, 3, 24'h00_000f);
        enIn <= 1'b1;
        repeat (60) @(posedge mclk);
        enIn <= 1'b0;
        repeat (300) @(posedge mclk);
        chk({29'h0, railGateOe}, 32'h0000_0007);
        t0 = int'(cyc);
        enIn <= 1'b1;
        waitOe(3'b000);
        chkWin(upAt[0] - t0, dly(15, 3, 1), 3);
        enIn <= 1'b0;
        waitOe(3'b111);
        // Enable falls after gate 1 is released.
        cfg(1, 0, 24'h11_0482);
        enIn <= 1'b1;
        waitOe(3'b110);
        repeat (5) @(posedge mclk);
        t0 = int'(cyc);
        enIn <= 1'b0;
        waitOe(3'b000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rd, {20'h0, 3'b111, 1'b1, 1'b0, 3'b111, tps_pkg::ST_SETTLE});
        waitOe(3'b111);
        chkWin(upAt[1] - t0, dly(8, 0, 0), 3);
        chkWin(upAt[2] - upAt[1], dly(4, 0, 0), 1);
        chkWin(dnAt[2] - upAt[2], SETTLE + dly(0, 0, 1), 0);
        chkWin(dnAt[1] - dnAt[2], dly(1, 0, 0), 1);
        // Enable returns during power-down.
        cfg(1, 0, 24'h22_2222);
        enIn <= 1'b1;
        waitOe(3'b000);
        enIn <= 1'b0;
        waitOe(3'b100);
        enIn <= 1'b1;
        waitOe(3'b111);
        waitOe(3'b000);
        chk(32'(dnAt[0] > dnAt[1]), 32'h0000_0001);
        chkWin(upAt[0] - dnAt[0], dly(2, 0, 1), 1);
        enIn <= 1'b0;
        waitOe(3'b111);
        endOfTest();
    end
endmodule

`default_nettype wire

// ---- tb/tps_reg_model.sv ----
`default_nettype none

module tps_reg_model (
    input wire logic mclk, // Master clock.
    input wire logic [2:0] railGateOe, // Gate pull-down enables.
    input wire logic [2:0] railGateOut, // Gate drive values.
    input wire logic [31:0] cyc, // Bench cycle count.
    output logic [2:0] pinLevel, // Resolved gate pin levels.
    output var int upAt [3], // Cycle at which each regulator was enabled.
    output var int dnAt [3] // Cycle at which each regulator was shut down.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] prevPin;

    // Regulator enable lines carry pull-ups, so a released gate reads high.
    assign pinLevel = (railGateOut & railGateOe) | ~railGateOe;

    // Start from a powered-off system with no events seen.
    initial begin
        prevPin = 3'h0;
        upAt = '{0, 0, 0};
        dnAt = '{0, 0, 0};
    end

    // Stamp each regulator switching; the bench judges order and spacing.
    always @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            if (pinLevel[i] === 1'b1 && prevPin[i] !== 1'b1) upAt[i] <= int'(cyc);
            if (pinLevel[i] === 1'b0 && prevPin[i] === 1'b1) dnAt[i] <= int'(cyc);
        end
        prevPin <= pinLevel;
    end
endmodule

`default_nettype wire
